// file: design/two_wire_pkg.sv
// constants, flag positions and state codes shared by the two-wire slave
package two_wire_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int FLAG_N = 7;

  // ****************************************
  // flag positions in the sticky status vector and the clear vector
  // ****************************************
  localparam int FLAG_ASYNC     = 0;
  localparam int FLAG_UNDERFLOW = 1;
  localparam int FLAG_NAK       = 2;
  localparam int FLAG_MISMATCH  = 3;
  localparam int FLAG_OVERFLOW  = 4;
  localparam int FLAG_BUS_FREE  = 5;
  localparam int FLAG_STOP      = 6;

  // ****************************************
  // counts and reset values
  // ****************************************
  localparam logic [3:0]        BITS_PER_BYTE = 4'h8;
  localparam logic [2:0]        TX_WINDOW_SCL = 3'h7;
  localparam logic [7:0]        BYTE_RESET    = 8'h00;
  localparam logic [FLAG_N-1:0] FLAG_RESET    = 7'h00;
  localparam logic [2:0]        PIN_IDLE      = 3'h7;

  // ****************************************
  // transfer states
  // ****************************************
  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ADDR     = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_TX_DATA  = 9'h008,
    ST_TX_ACK   = 9'h010,
    ST_TX_WAIT  = 9'h020,
    ST_RX_DATA  = 9'h040,
    ST_RX_ACK   = 9'h080,
    ST_IGNORE   = 9'h100
  } state_t;

endpackage

// file: design/bus_sense_if.sv
// synchronised bus levels and detected bus events
`timescale 1ns/100ps
interface bus_sense_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bfr_low;

  modport source (output scl, sda, scl_rise, scl_fall, start_det, stop_det, bfr_low);
  modport sink   (input  scl, sda, scl_rise, scl_fall, start_det, stop_det, bfr_low);
endinterface

// file: design/bus_sense.sv
// pin synchroniser with clock edge, start and stop detection
`timescale 1ns/100ps
module bus_sense (
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   scl_pin,
  input  wire logic   sda_pin,
  input  wire logic   bfr_pin_n,
  bus_sense_if.source sense
);

  logic [2:0] pins;
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] prev;
  logic [2:0] next_stage1;
  logic [2:0] next_stage2;
  logic [2:0] next_prev;

  assign pins = {bfr_pin_n, sda_pin, scl_pin};

  // ****************************************
  // two flops per pin, then one more for edges
  // ****************************************
  always_comb begin
    next_stage1 = pins;
    next_stage2 = stage1;
    next_prev   = stage2;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= two_wire_pkg::PIN_IDLE;
      stage2 <= two_wire_pkg::PIN_IDLE;
      prev   <= two_wire_pkg::PIN_IDLE;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      prev   <= next_prev;
    end
  end

  // ****************************************
  // events
  // ****************************************
  assign sense.scl       = stage2[0];
  assign sense.sda       = stage2[1];
  assign sense.scl_rise  = stage2[0] & ~prev[0];
  assign sense.scl_fall  = ~stage2[0] & prev[0];
  assign sense.start_det = stage2[0] & prev[0] & ~stage2[1] & prev[1]; // R25
  assign sense.stop_det  = stage2[0] & prev[0] & stage2[1] & ~prev[1]; // R25
  assign sense.bfr_low   = ~stage2[2];

endmodule

// file: design/scl_cycle_timer.sv
// counts serial clock rises while the transmit request stays open
`timescale 1ns/100ps
module scl_cycle_timer (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic arm,
  input  wire logic active,
  input  wire logic tick,
  output logic      expired
);

  logic [2:0] count;
  logic       running;
  logic [2:0] next_count;
  logic       next_running;
  logic       next_expired;

  always_comb begin
    next_count   = count;
    next_running = running;
    next_expired = 1'b0;
    if (arm) begin
      next_count   = 3'h0;
      next_running = 1'b1;
    end else if (!active) begin
      next_running = 1'b0;
    end else if (running && tick) begin
      next_count = count + 3'h1;
      if (next_count == two_wire_pkg::TX_WINDOW_SCL) begin
        next_expired = 1'b1;
        next_running = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count   <= 3'h0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
      expired <= next_expired;
    end
  end

endmodule

// file: design/two_wire_slave.sv
// two-wire bus slave: address match, transmit and receive flow, status flags
`timescale 1ns/100ps
// Summary of operation
// [R1] enable arms start watch; no disable mid-transfer
// [R2] own address with comm enabled: ACK, pick direction
// [R3] comm disabled: own address left unanswered
// [R4] busy start-to-stop, selected, direction kept
// [R5] async detect: flag, bus event, NAK
// [R6] selected with read direction requests transmit data
// [R7] byte moved to shifter sets empty; write clears
// [R8] no stretch: first byte within one clock
// [R9] stretch sends stale byte; clear bit zeroes buffer (code sends it only without stretch; stretch waits for a write)
// [R10] bytes written during async detect are dropped
// [R11] no write in seven clocks: resend, underflow
// [R12] stretch: hold clock low until buffer written
// [R13] bits out MSB first; master answers ninth clock
// [R14] master ACK stretches, clears NAK; NAK sets flag
// [R15] driven bit differs from line: mismatch flag
// [R16] master waits 33 us after fast NAK
// [R17] write direction: shift eight bits, receive ready
// [R18] no stretch read in seven; stretch holds clock
// [R19] unread byte overwritten sets overflow flag
// [R20] answer ACK or NAK from nak answer bit
// [R21] stop while selected: flag, release, back idle
// [R22] software checks busy, selected before disabling comm
// [R23] peripheral clock at least eight times serial clock
// [R24] bus free pulse: flag, reset transfer, release lines
// [R25] lines synchronised; start and stop detected
module two_wire_slave (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  input  wire logic        bus_free_request_n,
  input  wire logic        module_enable,
  input  wire logic        comm_enable,
  input  wire logic        clk_stretch_enable,
  input  wire logic        async_addr_detect_enable,
  input  wire logic        bus_free_request_enable,
  input  wire logic        nak_answer,
  input  wire logic        tx_buffer_clear,
  input  wire logic [6:0]  own_address,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_write,
  input  wire logic        rx_read,
  input  wire logic [6:0]  flag_clear,
  output logic      [7:0]  rx_data_reg,
  output logic             busy,
  output logic             selected,
  output logic             rw_dir,
  output logic             tx_empty,
  output logic             rx_ready,
  output logic             async_addr_hit,
  output logic             tx_underflow,
  output logic             master_nak_flag,
  output logic             sda_mismatch,
  output logic             rx_overflow,
  output logic             stop_seen,
  output logic             bus_free_flag,
  output logic             bus_event
);

  bus_sense_if sense ();

  two_wire_pkg::state_t state;
  two_wire_pkg::state_t next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [7:0]  tx_data_reg;
  logic [7:0]  next_tx_data_reg;
  logic [7:0]  next_rx_data_reg;
  logic [6:0]  flags;
  logic [6:0]  next_flags;
  logic [6:0]  flag_set;
  logic        next_busy;
  logic        next_selected;
  logic        next_rw_dir;
  logic        next_tx_empty;
  logic        next_rx_ready;
  logic        next_sda_oe;
  logic        next_scl_oe;
  logic        next_bus_event;
  logic        clear_prev;
  logic        async_prev;
  logic        tx_load;
  logic        rx_load;
  logic        raise_tx_empty;
  logic        nak_clear;
  logic        bfr_event;
  logic        tx_window_over;

  bus_sense sense_unit (
    .clock     (clock),
    .rst_n     (rst_n),
    .scl_pin   (serial_clock_pin_in),
    .sda_pin   (serial_data_pin_in),
    .bfr_pin_n (bus_free_request_n),
    .sense     (sense.source)
  );

  scl_cycle_timer tx_window (
    .clock   (clock),
    .rst_n   (rst_n),
    .arm     (raise_tx_empty && !clk_stretch_enable), // R11
    .active  (tx_empty),
    .tick    (sense.scl_rise),
    .expired (tx_window_over)
  );

  assign bfr_event = bus_free_request_enable && sense.bfr_low;

  // ****************************************
  // transfer sequencing
  // ****************************************
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_busy      = busy;
    next_selected  = selected;
    next_rw_dir    = rw_dir;
    flag_set       = two_wire_pkg::FLAG_RESET;
    tx_load        = 1'b0;
    rx_load        = 1'b0;
    raise_tx_empty = 1'b0;
    nak_clear      = 1'b0;
    unique case (state)
      two_wire_pkg::ST_IDLE, two_wire_pkg::ST_IGNORE: begin
      end
      two_wire_pkg::ST_ADDR: begin
        if (sense.scl_rise) begin
          next_shift   = {shift[6:0], sense.sda};
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (sense.scl_fall && bit_cnt == two_wire_pkg::BITS_PER_BYTE) begin
          next_bit_cnt = 4'h0;
          next_state   = two_wire_pkg::ST_IGNORE;
          if (shift[7:1] == own_address) begin
            if (async_addr_detect_enable) begin
              flag_set[two_wire_pkg::FLAG_ASYNC] = 1'b1; // R5
            end else if (comm_enable) begin // R3
              next_selected  = 1'b1; // R4
              next_rw_dir    = shift[0]; // R4
              next_state     = two_wire_pkg::ST_ADDR_ACK; // R2
              raise_tx_empty = shift[0]; // R6
            end
          end
        end
      end
      two_wire_pkg::ST_ADDR_ACK, two_wire_pkg::ST_TX_ACK: begin
        if (sense.scl_rise) begin
          next_bit_cnt = 4'h1;
          if (state == two_wire_pkg::ST_TX_ACK) begin
            if (sense.sda) begin
              flag_set[two_wire_pkg::FLAG_NAK] = 1'b1; // R14
              next_state = two_wire_pkg::ST_IGNORE;
            end else begin
              nak_clear = 1'b1; // R14
            end
          end
        end else if (sense.scl_fall && bit_cnt != 4'h0) begin
          next_bit_cnt = 4'h0;
          if (!rw_dir) begin
            next_state = two_wire_pkg::ST_RX_DATA;
          end else if (clk_stretch_enable && tx_empty) begin
            next_state = two_wire_pkg::ST_TX_WAIT; // R14
          end else begin
            tx_load    = 1'b1; // R8
            next_state = two_wire_pkg::ST_TX_DATA;
          end
        end
      end
      two_wire_pkg::ST_TX_WAIT: begin
        if (!tx_empty) begin
          tx_load    = 1'b1; // R12
          next_state = two_wire_pkg::ST_TX_DATA;
        end
      end
      two_wire_pkg::ST_TX_DATA: begin
        if (sense.scl_rise) begin
          next_bit_cnt = bit_cnt + 4'h1;
          if (sense.sda != shift[7]) begin
            flag_set[two_wire_pkg::FLAG_MISMATCH] = 1'b1; // R15
          end
        end else if (sense.scl_fall) begin
          if (bit_cnt == two_wire_pkg::BITS_PER_BYTE) begin
            next_bit_cnt = 4'h0;
            next_state   = two_wire_pkg::ST_TX_ACK; // R13
          end else begin
            next_shift = {shift[6:0], 1'b0}; // R13
          end
        end
      end
      two_wire_pkg::ST_RX_DATA: begin
        if (sense.scl_rise) begin
          next_shift   = {shift[6:0], sense.sda}; // R17
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (sense.scl_fall && bit_cnt == two_wire_pkg::BITS_PER_BYTE) begin
          rx_load      = 1'b1; // R17
          next_bit_cnt = 4'h0;
          next_state   = two_wire_pkg::ST_RX_ACK;
          flag_set[two_wire_pkg::FLAG_OVERFLOW] = rx_ready && !rx_read; // R19
        end
      end
      two_wire_pkg::ST_RX_ACK: begin
        if (sense.scl_rise) begin
          next_bit_cnt = 4'h1;
        end else if (sense.scl_fall && bit_cnt != 4'h0) begin
          next_bit_cnt = 4'h0;
          next_state   = two_wire_pkg::ST_RX_DATA;
        end
      end
      default: begin
        next_state = two_wire_pkg::ST_IDLE;
      end
    endcase
    if (tx_load) begin
      next_shift     = tx_data_reg;
      raise_tx_empty = 1'b1; // R7
    end
    if (sense.start_det) begin
      next_busy     = 1'b1; // R4
      next_selected = 1'b0; // R4
      next_state    = two_wire_pkg::ST_ADDR;
      next_bit_cnt  = 4'h0;
      flag_set[two_wire_pkg::FLAG_STOP] = selected;
    end
    if (sense.stop_det) begin
      next_busy     = 1'b0; // R21
      next_selected = 1'b0; // R21
      next_state    = two_wire_pkg::ST_IDLE; // R21
      flag_set[two_wire_pkg::FLAG_STOP] = selected; // R21
    end
    if (bfr_event) begin
      flag_set[two_wire_pkg::FLAG_BUS_FREE] = 1'b1; // R24
      next_state    = two_wire_pkg::ST_IDLE; // R24
      next_busy     = 1'b0;
      next_selected = 1'b0;
    end
    if (!module_enable) begin
      next_state    = two_wire_pkg::ST_IDLE; // R1
      next_busy     = 1'b0;
      next_selected = 1'b0;
    end
    flag_set[two_wire_pkg::FLAG_UNDERFLOW] = tx_window_over; // R11
  end

  // ****************************************
  // line drivers, open drain: enable pulls low
  // ****************************************
  always_comb begin
    next_sda_oe = (next_state == two_wire_pkg::ST_ADDR_ACK)
                || (next_state == two_wire_pkg::ST_RX_ACK && !nak_answer) // R20
                || (next_state == two_wire_pkg::ST_TX_DATA && !next_shift[7]); // R13
    next_scl_oe = (next_state == two_wire_pkg::ST_TX_WAIT) // R12
                || (next_state == two_wire_pkg::ST_RX_ACK && next_bit_cnt == 4'h0
                    && clk_stretch_enable && next_rx_ready); // R18
  end

  // ****************************************
  // buffers and request flags
  // ****************************************
  always_comb begin
    next_tx_data_reg = tx_data_reg;
    if (tx_write) begin
      next_tx_data_reg = tx_byte; // R8
    end
    if (clear_prev && !tx_buffer_clear) begin
      next_tx_data_reg = two_wire_pkg::BYTE_RESET; // R9
    end
    if (async_prev && !async_addr_detect_enable) begin
      next_tx_data_reg = two_wire_pkg::BYTE_RESET; // R10
    end
    next_tx_empty    = (tx_empty && !tx_write) || raise_tx_empty; // R7
    next_rx_ready    = (rx_ready && !rx_read) || rx_load; // R17
    next_rx_data_reg = rx_load ? shift : rx_data_reg; // R19
  end

  // ****************************************
  // sticky flags, cleared by writing one; a set wins
  // ****************************************
  for (genvar i = 0; i < two_wire_pkg::FLAG_N; i++) begin : g_flag
    always_comb begin
      next_flags[i] = flag_set[i]
                    || (flags[i] && !flag_clear[i]
                        && !(i == two_wire_pkg::FLAG_NAK && nak_clear));
    end
  end

  always_comb begin
    next_bus_event = |next_flags; // R5
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state               <= two_wire_pkg::ST_IDLE;
      bit_cnt             <= 4'h0;
      shift               <= two_wire_pkg::BYTE_RESET;
      tx_data_reg         <= two_wire_pkg::BYTE_RESET;
      rx_data_reg         <= two_wire_pkg::BYTE_RESET;
      flags               <= two_wire_pkg::FLAG_RESET;
      busy                <= 1'b0;
      selected            <= 1'b0;
      rw_dir              <= 1'b0;
      tx_empty            <= 1'b0;
      rx_ready            <= 1'b0;
      serial_data_pin_oe  <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      bus_event           <= 1'b0;
      clear_prev          <= 1'b0;
      async_prev          <= 1'b0;
    end else begin
      state               <= next_state;
      bit_cnt             <= next_bit_cnt;
      shift               <= next_shift;
      tx_data_reg         <= next_tx_data_reg;
      rx_data_reg         <= next_rx_data_reg;
      flags               <= next_flags;
      busy                <= next_busy;
      selected            <= next_selected;
      rw_dir              <= next_rw_dir;
      tx_empty            <= next_tx_empty;
      rx_ready            <= next_rx_ready;
      serial_data_pin_oe  <= next_sda_oe;
      serial_clock_pin_oe <= next_scl_oe;
      bus_event           <= next_bus_event;
      clear_prev          <= tx_buffer_clear;
      async_prev          <= async_addr_detect_enable;
    end
  end

  assign serial_data_pin_out  = 1'b0;
  assign serial_clock_pin_out = 1'b0;
  assign async_addr_hit       = flags[two_wire_pkg::FLAG_ASYNC];
  assign tx_underflow         = flags[two_wire_pkg::FLAG_UNDERFLOW];
  assign master_nak_flag      = flags[two_wire_pkg::FLAG_NAK];
  assign sda_mismatch         = flags[two_wire_pkg::FLAG_MISMATCH];
  assign rx_overflow          = flags[two_wire_pkg::FLAG_OVERFLOW];
  assign bus_free_flag        = flags[two_wire_pkg::FLAG_BUS_FREE];
  assign stop_seen            = flags[two_wire_pkg::FLAG_STOP];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  stop_release_a: assert property (sense.stop_det && selected && module_enable |=> // R21
    !selected && !busy && stop_seen && !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("stop while selected did not release the slave");
  busy_start_a: assert property (sense.start_det && module_enable && !bfr_event |=> busy) // R4
    else $error("start did not set busy");
  sel_enable_a: assert property ($rose(selected) |-> $past(comm_enable) // R3
    && !$past(async_addr_detect_enable))
    else $error("selected without communication enabled");
  addr_ack_a: assert property ($rose(selected) |-> serial_data_pin_oe) // R2
    else $error("own address not acknowledged");
  async_nak_a: assert property ($rose(async_addr_hit) |-> !selected && !serial_data_pin_oe // R5
    ##1 bus_event)
    else $error("async address hit was answered");
  tx_load_a: assert property (tx_load |=> tx_empty && shift == $past(tx_data_reg)) // R7
    else $error("transmit byte load wrong");
  tx_write_a: assert property (tx_write && !raise_tx_empty |=> !tx_empty) // R7
    else $error("write did not clear transmit empty");
  tx_stretch_a: assert property (state == two_wire_pkg::ST_TX_WAIT && tx_empty |-> // R12
    serial_clock_pin_oe)
    else $error("clock not held while waiting for data");
  rx_copy_a: assert property (rx_load |=> rx_ready && rx_data_reg == $past(shift)) // R17
    else $error("received byte not copied");
  overflow_a: assert property (rx_load && rx_ready && !rx_read |=> rx_overflow) // R19
    else $error("overwrite did not flag overflow");
  mismatch_a: assert property (state == two_wire_pkg::ST_TX_DATA && sense.scl_rise // R15
    && sense.sda != shift[7] |=> sda_mismatch)
    else $error("line mismatch not flagged");
  master_nak_a: assert property (state == two_wire_pkg::ST_TX_ACK && sense.scl_rise // R14
    && sense.sda && module_enable && !bfr_event |=> master_nak_flag && !serial_clock_pin_oe)
    else $error("master NAK not handled");
  bus_free_a: assert property (bfr_event |=> bus_free_flag && !busy // R24
    && !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("bus free request did not release");
  disable_a: assert property (!module_enable |=> state == two_wire_pkg::ST_IDLE && !selected) // R1
    else $error("disabled slave left idle");

  tx_select_c: cover property ($rose(selected) && rw_dir);
  rx_select_c: cover property ($rose(selected) && !rw_dir);
  stop_c: cover property ($rose(stop_seen));
  underflow_c: cover property ($rose(tx_underflow));

endmodule

// file: tb/bus_master_model.sv
// two-wire bus master model that drives the slave's serial lines
`timescale 1ns/100ps
module bus_master_model (
  input  wire logic clock,
  input  wire logic scl_oe_dut,
  input  wire logic sda_oe_dut,
  output logic      scl,
  output logic      sda,
  output logic      stuck
);
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;

  // both lines are pulled up; any party pulling low wins
  assign scl = !(scl_lo || scl_oe_dut);
  assign sda = !(sda_lo || sda_oe_dut);

  initial stuck = 1'b0;

  // half of an 80 ns serial clock period
  task automatic half();
    repeat (4) @(posedge clock);
  endtask

  task automatic start();
    sda_lo <= 1'b1;
    half();
    scl_lo <= 1'b1;
    half();
  endtask

  task automatic stop();
    @(posedge clock);
    sda_lo <= 1'b1;
    half();
    scl_lo <= 1'b0;
    half();
    sda_lo <= 1'b0;
    half();
  endtask

  // nine bits msb first; bit 0 is the acknowledge slot, 1 leaves sda released
  task automatic xfer(input logic [8:0] out, output logic [8:0] got);
    int n;
    for (int i = 8; i >= 0; i--) begin
      @(posedge clock);
      sda_lo <= !out[i];
      repeat (3) @(posedge clock);
      scl_lo <= 1'b0;
      @(posedge clock);
      n = 0;
      // a held clock line is waited out, but never for ever
      while (!scl && n < 3000) begin
        @(posedge clock);
        n++;
      end
      if (n >= 3000) stuck = 1'b1;
      repeat (3) @(posedge clock);
      got[i] = sda;
      scl_lo <= 1'b1;
    end
  endtask
endmodule

// file: tb/test_two_wire_slave.sv
// self-checking bench for the two-wire slave
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t value mismatch", $time); end end
module test_two_wire_slave;
  localparam logic [6:0] ADDR = 7'h2a;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic module_enable = 1'b1;
  logic comm_enable = 1'b1;
  logic nak_answer = 1'b0;
  logic bfr_enable = 1'b0;
  logic bfr_n = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  logic tx_write = 1'b0;
  logic rx_read = 1'b0;
  logic stretch = 1'b0;
  logic async_en = 1'b0;
  logic tx_clear = 1'b0;
  logic [6:0] flag_clear = 7'h00;
  logic [7:0] rx_data_reg;
  logic scl, sda, scl_oe, sda_oe, stuck, busy, selected, rw_dir, tx_empty, rx_ready;
  logic async_hit, tx_underflow, master_nak_flag, sda_mismatch, rx_overflow;
  logic stop_seen, bus_free_flag, bus_event;
  int errors = 0;
  int comparisons = 0;

  always #5 clock = !clock;

  bus_master_model u_master (.clock(clock), .scl_oe_dut(scl_oe), .sda_oe_dut(sda_oe),
    .scl(scl), .sda(sda), .stuck(stuck));

  two_wire_slave u_dut (.clock(clock), .rst_n(rst_n), .serial_clock_pin_in(scl),
    .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda),
    .serial_data_pin_out(), .serial_data_pin_oe(sda_oe), .bus_free_request_n(bfr_n),
    .module_enable(module_enable), .comm_enable(comm_enable), .clk_stretch_enable(stretch),
    .async_addr_detect_enable(async_en), .bus_free_request_enable(bfr_enable),
    .nak_answer(nak_answer), .tx_buffer_clear(tx_clear), .own_address(ADDR),
    .tx_byte(tx_byte), .tx_write(tx_write), .rx_read(rx_read), .flag_clear(flag_clear),
    .rx_data_reg(rx_data_reg), .busy(busy), .selected(selected), .rw_dir(rw_dir),
    .tx_empty(tx_empty), .rx_ready(rx_ready), .async_addr_hit(async_hit),
    .tx_underflow(tx_underflow), .master_nak_flag(master_nak_flag),
    .sda_mismatch(sda_mismatch), .rx_overflow(rx_overflow), .stop_seen(stop_seen),
    .bus_free_flag(bus_free_flag), .bus_event(bus_event));

  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic clear_flags();
    flag_clear <= 7'h7f;
    @(posedge clock);
    flag_clear <= 7'h00;
    repeat (2) @(posedge clock);
    `CHK({stop_seen, rx_overflow, master_nak_flag, sda_mismatch, bus_event}, 5'h00)
  endtask

  task automatic write_flow();
    logic [8:0] g;
    u_master.start();
    u_master.xfer({ADDR, 1'b0, 1'b1}, g);
    `CHK(g[0], 1'b0)
    `CHK({busy, selected, rw_dir}, 3'b110)
    u_master.xfer({8'h3c, 1'b1}, g);
    `CHK(g[0], 1'b0)
    `CHK({rx_ready, rx_data_reg}, 9'h13c)
    nak_answer <= 1'b1;
    u_master.xfer({8'hc3, 1'b1}, g);
    `CHK(g[0], 1'b1)
    `CHK({rx_overflow, rx_data_reg}, 9'h1c3)
    rx_read <= 1'b1;
    @(posedge clock);
    rx_read <= 1'b0;
    @(posedge clock);
    `CHK(rx_ready, 1'b0)
    u_master.stop();
    repeat (6) @(posedge clock);
    `CHK({busy, selected, stop_seen, bus_event, scl_oe, sda_oe}, 6'b001100)
    nak_answer <= 1'b0;
    clear_flags();
  endtask

  task automatic refuse_flow();
    logic [8:0] g;
    `CHK({busy, selected}, 2'b00)
    comm_enable <= 1'b0;
    u_master.start();
    u_master.xfer({ADDR, 1'b0, 1'b1}, g);
    `CHK({g[0], busy, selected}, 3'b110)
    module_enable <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(busy, 1'b0)
    module_enable <= 1'b1;
    u_master.stop();
    repeat (6) @(posedge clock);
    `CHK({busy, stop_seen}, 2'b00)
    comm_enable <= 1'b1;
  endtask

  task automatic read_flow();
    logic [8:0] g;
    tx_byte <= 8'ha5;
    tx_write <= 1'b1;
    @(posedge clock);
    tx_write <= 1'b0;
    u_master.start();
    u_master.xfer({ADDR, 1'b1, 1'b1}, g);
    `CHK(g[0], 1'b0)
    `CHK({selected, rw_dir, tx_empty}, 3'b111)
    // the master holds the msb low against a driven one
    u_master.xfer({8'h7f, 1'b1}, g);
    repeat (3) @(posedge clock);
    `CHK(g[8:1], 8'h25)
    `CHK(sda_mismatch, 1'b1)
    `CHK(master_nak_flag, 1'b1)
    `CHK(tx_underflow, 1'b1)
    u_master.stop();
    repeat (6) @(posedge clock);
    clear_flags();
  endtask

  task automatic stretch_flow();
    logic [8:0] g;
    stretch <= 1'b1;
    tx_clear <= 1'b1;
    @(posedge clock);
    tx_clear <= 1'b0;
    @(posedge clock);
    u_master.start();
    u_master.xfer({ADDR, 1'b1, 1'b1}, g);
    fork
      u_master.xfer({8'hff, 1'b1}, g);
      begin
        repeat (40) @(posedge clock);
        `CHK({scl, scl_oe, tx_empty}, 3'b011)
        tx_byte <= 8'h96;
        tx_write <= 1'b1;
        @(posedge clock);
        tx_write <= 1'b0;
      end
    join
    `CHK(g[8:1], 8'h96)
    u_master.stop();
    u_master.start();
    u_master.xfer({ADDR, 1'b0, 1'b1}, g);
    fork
      u_master.xfer({8'h5a, 1'b1}, g);
      begin
        repeat (120) @(posedge clock);
        `CHK({scl_oe, rx_ready, rx_data_reg}, 10'h35a)
        rx_read <= 1'b1;
        @(posedge clock);
        rx_read <= 1'b0;
      end
    join
    `CHK({g[0], rx_ready}, 2'b00)
    stretch <= 1'b0;
    u_master.stop();
    clear_flags();
  endtask

  task automatic async_flow();
    logic [8:0] g;
    async_en <= 1'b1;
    tx_byte <= 8'h5a;
    tx_write <= 1'b1;
    @(posedge clock);
    tx_write <= 1'b0;
    u_master.start();
    u_master.xfer({ADDR, 1'b1, 1'b1}, g);
    `CHK({g[0], selected, async_hit, bus_event}, 4'b1011)
    u_master.stop();
    async_en <= 1'b0;
    repeat (3300) @(posedge clock);
    u_master.start();
    u_master.xfer({ADDR, 1'b1, 1'b1}, g);
    u_master.xfer({8'hff, 1'b1}, g);
    `CHK({g[8:1], tx_underflow}, 9'h001)
    u_master.stop();
    clear_flags();
  endtask

  task automatic bus_free_flow();
    bfr_enable <= 1'b1;
    @(posedge clock);
    bfr_n <= 1'b0;
    repeat (2) @(posedge clock);
    bfr_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK({bus_free_flag, bus_event, scl_oe, sda_oe}, 4'b1100)
    bfr_enable <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK({busy, selected, tx_empty, rx_ready, bus_event, scl_oe, sda_oe}, 7'h00)
    write_flow();
    refuse_flow();
    read_flow();
    stretch_flow();
    async_flow();
    bus_free_flow();
    `CHK(stuck, 1'b0)
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    stop_test();
  end
endmodule
